//--- include/ctq_regs.svh
`ifndef CTQ_REGS_SVH
`define CTQ_REGS_SVH

// ----------------------------------------
// register word indices
// ----------------------------------------
`define CTQ_IDX_CTRL 4'h0
`define CTQ_IDX_STAT 4'h1
`define CTQ_IDX_UADDR 4'h2
`define CTQ_IDX_FIFO 4'h3

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CTQ_PLSZ_HI 31
`define CTQ_PLSZ_LO 29
`define CTQ_DEPTH_HI 28
`define CTQ_DEPTH_LO 24
`define CTQ_RETRY_HI 22
`define CTQ_RETRY_LO 21
`define CTQ_PRIO_HI 20
`define CTQ_PRIO_LO 16
`define CTQ_FLUSH_BIT 10
`define CTQ_SEND_BIT 9
`define CTQ_ADV_BIT 8
`define CTQ_DIR_BIT 7
`define CTQ_ARBRT_BIT 6
`define CTQ_TSEN_BIT 5
`define CTQ_ATIE_BIT 4
`define CTQ_OVIE_BIT 3
`define CTQ_EMIE_BIT 2
`define CTQ_HLIE_BIT 1
`define CTQ_NFIE_BIT 0

// ----------------------------------------
// status register fields
// ----------------------------------------
`define CTQ_IDX_HI 12
`define CTQ_IDX_LO 8
`define CTQ_ABT_BIT 7
`define CTQ_LARB_BIT 6
`define CTQ_BERR_BIT 5
`define CTQ_ATIF_BIT 4
`define CTQ_EMPTY_BIT 2
`define CTQ_NFULL_BIT 0

// ----------------------------------------
// byte lanes and reset values
// ----------------------------------------
`define CTQ_LANE0 0
`define CTQ_LANE1 1
`define CTQ_LANE2 2
`define CTQ_LANE3 3
`define CTQ_RETRY_RST 2'h3
`define CTQ_HDR_BYTES 7'h08

// ----------------------------------------
// retry modes presented to the engine
// ----------------------------------------
`define CTQ_RETRY_NONE 2'h0
`define CTQ_RETRY_THREE 2'h1
`define CTQ_RETRY_ENDLESS 2'h2

`endif

//--- include/ctq_pkg.sv
package ctq_pkg;

    // send handshake state
    typedef enum logic [1:0] {
        CTQ_IDLE = 2'b00,
        CTQ_SENDING = 2'b01,
        CTQ_ABORTING = 2'b10
    } ctq_state_e;

    typedef logic [4:0] ctq_index_t;

endpackage : ctq_pkg

//--- hw/ctq_fifo_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctq_regs.svh"

module ctq_fifo_ctrl
    import ctq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // controller mode
    input wire logic configMode,
    // register write
    input wire logic wrEn,
    input wire logic [3:0] wrByteEn,
    input wire logic [31:0] wrData,
    // readback and configuration
    output logic [31:0] ctrlWord,
    output logic fifoIsTransmit
);

    logic [2:0] payload_size_reg;
    logic [4:0] depth_reg;
    logic [1:0] retry_reg;
    logic [4:0] prio_reg;
    logic dir_reg;
    logic remoteReply_reg;
    logic tsEn_reg;
    logic [4:0] irqEn_reg;
    logic flush_reg;

    // ----------------------------------------
    // configuration fields, config mode only
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            payload_size_reg <= 3'h0;
            depth_reg <= 5'h00;
            dir_reg <= 1'b0;
            tsEn_reg <= 1'b0;
        end else if (wrEn && configMode) begin
            if (wrByteEn[`CTQ_LANE3]) begin
                payload_size_reg <= wrData[`CTQ_PLSZ_HI:`CTQ_PLSZ_LO];
                depth_reg <= wrData[`CTQ_DEPTH_HI:`CTQ_DEPTH_LO];
            end
            if (wrByteEn[`CTQ_LANE0]) begin
                dir_reg <= wrData[`CTQ_DIR_BIT];
                tsEn_reg <= wrData[`CTQ_TSEN_BIT];
            end
        end
    end

    // ----------------------------------------
    // freely writable fields
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            retry_reg <= `CTQ_RETRY_RST;
            prio_reg <= 5'h00;
            remoteReply_reg <= 1'b0;
            irqEn_reg <= 5'h00;
        end else if (wrEn) begin
            if (wrByteEn[`CTQ_LANE2]) begin
                retry_reg <= wrData[`CTQ_RETRY_HI:`CTQ_RETRY_LO];
                prio_reg <= wrData[`CTQ_PRIO_HI:`CTQ_PRIO_LO];
            end
            if (wrByteEn[`CTQ_LANE0]) begin
                remoteReply_reg <= wrData[`CTQ_ARBRT_BIT];
                irqEn_reg <= wrData[`CTQ_ATIE_BIT:`CTQ_NFIE_BIT];
            end
        end
    end

    // ----------------------------------------
    // reset bit, held in config mode
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flush_reg <= 1'b1;
        end else if (configMode) begin
            flush_reg <= 1'b1;
        end else if (wrEn && wrByteEn[`CTQ_LANE1] && wrData[`CTQ_FLUSH_BIT]) begin
            flush_reg <= 1'b1;
        end else begin
            flush_reg <= 1'b0;
        end
    end

    // readback word
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrlWord <= 32'h00000000;
            fifoIsTransmit <= 1'b0;
        end else begin
            ctrlWord <= {payload_size_reg, depth_reg, 1'b0, retry_reg, prio_reg, 5'h00, flush_reg, 2'b00,
                         dir_reg, remoteReply_reg, tsEn_reg, irqEn_reg};
            fifoIsTransmit <= dir_reg;
        end
    end

endmodule : ctq_fifo_ctrl
`default_nettype wire

//--- hw/ctq_tx_queue.sv
// Behaviour
// - Writing one to reset bit resets queue; bit self-clears; host waits for zero.
// - Reset bit stays set in Configuration mode, clears in Normal mode.
// - Send request starts sending; clears after all queued messages sent, or on abort or queue reset.
// - Writing zero to send request while set requests an abort.
// - Send request updates on completion, abort and queue reset.
// - Pointer advance moves queue head forward exactly one slot.
// - Direction bit of transmit queue always reads one.
// - Size, depth and similar configuration fields writable only in Configuration mode.
// - Aborted, lost-arbitration, bus-error bits record last message outcome.
// - Completion status bits update on complete, abort or queue reset.
// - Completion status bits clear when send request set or written zero.
// - Attempts-exhausted flag pends when retries run out; enable gates interrupt.
// - Message index gives zero-based slot of next message to send.
// - Empty flag reads one with no message queued, else zero.
// - Not-full flag reads one while a slot is free, zero when full.
// - Empty and not-full enables gate their interrupts.
// - User address register reads message RAM address of queue head.
// - Payload code 000..111 selects 8,12,16,20,24,32,48,64 bytes.
// - Depth is field value plus one, 1 to 32 messages.
// - With global retry limit set, attempts field selects none, three or unlimited.
// - Priority field ranks queues, 11111 highest, 00000 lowest.
// - FIFO direction bit: one transmit, zero receive.
`timescale 1ns/1ps
`default_nettype none
`include "ctq_regs.svh"

module ctq_tx_queue
    import ctq_pkg::*;
#(
    parameter logic [31:0] RAM_BASE = 32'h00000400
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // controller mode and global option
    input wire logic configMode,
    input wire logic retryLimitGlobal,
    // register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [3:0] regAddr,
    input wire logic [3:0] regByteEn,
    input wire logic [31:0] regWData,
    output logic [31:0] regRData,
    output logic regRValid,
    // protocol engine events
    input wire logic msgSent,
    input wire logic msgAborted,
    input wire logic arbLost,
    input wire logic busError,
    input wire logic attemptsOut,
    // to protocol engine
    output logic sendPending,
    output logic abortRequest,
    output logic [4:0] sendPriority,
    output logic [1:0] retryMode,
    output logic [4:0] queueIndex,
    output logic [31:0] headAddress,
    output logic flushBusy,
    // interrupt requests
    output logic emptyIrq,
    output logic notFullIrq,
    output logic attemptsIrq,
    // general fifo
    output logic fifoIsTransmit
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // payload bytes per slot
    function automatic logic [6:0] payloadBytes(input logic [2:0] code);
        case (code)
            3'h0: payloadBytes = 7'h08;
            3'h1: payloadBytes = 7'h0C;
            3'h2: payloadBytes = 7'h10;
            3'h3: payloadBytes = 7'h14;
            3'h4: payloadBytes = 7'h18;
            3'h5: payloadBytes = 7'h20;
            3'h6: payloadBytes = 7'h30;
            default: payloadBytes = 7'h40;
        endcase
    endfunction : payloadBytes

    // slot index step with wrap at depth
    function automatic ctq_index_t nextSlot(input ctq_index_t cur, input logic [4:0] lastSlot);
        nextSlot = (cur == lastSlot) ? 5'h00 : 5'(cur + 5'h01);
    endfunction : nextSlot

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [2:0] payload_size_reg;
    logic [4:0] depth_reg;
    logic [1:0] retry_reg;
    logic [4:0] prio_reg;
    logic flush_reg;
    logic sendReq_reg;
    logic atIe_reg;
    logic emIe_reg;
    logic nfIe_reg;
    logic abt_reg;
    logic larb_reg;
    logic berr_reg;
    logic atIf_reg;
    logic larbSeen_reg;
    logic berrSeen_reg;
    ctq_index_t head_reg;
    ctq_index_t tail_reg;
    logic [5:0] count_reg;
    ctq_state_e state_reg;
    logic [31:0] fifoWord;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic wrCtrl;
    logic wrStat;
    logic wrFifo;
    logic setSend;
    logic abortWr;
    logic advWr;
    logic flushDone;
    logic queueEmpty;
    logic queueFull;
    logic advance;
    logic finish;
    logic [5:0] depthMsgs;

    // decoded strobes
    assign wrCtrl = regWrite && (regAddr == `CTQ_IDX_CTRL);
    assign wrStat = regWrite && (regAddr == `CTQ_IDX_STAT);
    assign wrFifo = regWrite && (regAddr == `CTQ_IDX_FIFO);
    assign setSend = wrCtrl && regByteEn[`CTQ_LANE1] && regWData[`CTQ_SEND_BIT] && !flush_reg;
    assign abortWr = wrCtrl && regByteEn[`CTQ_LANE1] && !regWData[`CTQ_SEND_BIT] && sendReq_reg;
    assign advWr = wrCtrl && regByteEn[`CTQ_LANE1] && regWData[`CTQ_ADV_BIT];
    assign flushDone = flush_reg && !configMode;
    // occupancy flags
    assign depthMsgs = {1'b0, depth_reg} + 6'h01;
    assign queueEmpty = (count_reg == 6'h00);
    assign queueFull = (count_reg == depthMsgs);
    assign advance = advWr && !queueFull && !flush_reg;
    assign finish = msgSent && !queueEmpty && !flush_reg;

    // ----------------------------------------
    // configuration fields
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            payload_size_reg <= 3'h0;
            depth_reg <= 5'h00;
        end else if (wrCtrl && configMode && regByteEn[`CTQ_LANE3]) begin
            payload_size_reg <= regWData[`CTQ_PLSZ_HI:`CTQ_PLSZ_LO];
            depth_reg <= regWData[`CTQ_DEPTH_HI:`CTQ_DEPTH_LO];
        end
    end

    // retry, priority and interrupt enables
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            retry_reg <= `CTQ_RETRY_RST;
            prio_reg <= 5'h00;
            atIe_reg <= 1'b0;
            emIe_reg <= 1'b0;
            nfIe_reg <= 1'b0;
        end else if (wrCtrl) begin
            if (regByteEn[`CTQ_LANE2]) begin
                retry_reg <= regWData[`CTQ_RETRY_HI:`CTQ_RETRY_LO];
                prio_reg <= regWData[`CTQ_PRIO_HI:`CTQ_PRIO_LO];
            end
            if (regByteEn[`CTQ_LANE0]) begin
                atIe_reg <= regWData[`CTQ_ATIE_BIT];
                emIe_reg <= regWData[`CTQ_EMIE_BIT];
                nfIe_reg <= regWData[`CTQ_NFIE_BIT];
            end
        end
    end

    // ----------------------------------------
    // queue reset bit
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flush_reg <= 1'b1;
        end else if (configMode) begin
            flush_reg <= 1'b1;
        end else if (flush_reg) begin
            flush_reg <= 1'b0;
        end else if (wrCtrl && regByteEn[`CTQ_LANE1] && regWData[`CTQ_FLUSH_BIT]) begin
            flush_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // head, tail and occupancy
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b || flushDone) begin
            head_reg <= 5'h00;
            tail_reg <= 5'h00;
            count_reg <= 6'h00;
        end else begin
            if (advance) begin
                head_reg <= nextSlot(head_reg, depth_reg);
            end
            if (finish) begin
                tail_reg <= nextSlot(tail_reg, depth_reg);
            end
            if (advance && !finish) begin
                count_reg <= count_reg + 6'h01;
            end else if (finish && !advance) begin
                count_reg <= count_reg - 6'h01;
            end
        end
    end

    // ----------------------------------------
    // send handshake
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b || flushDone) begin
            state_reg <= CTQ_IDLE;
            sendReq_reg <= 1'b0;
        end else begin
            case (state_reg)
                CTQ_IDLE: begin
                    if (setSend) begin
                        sendReq_reg <= 1'b1;
                        state_reg <= CTQ_SENDING;
                    end
                end
                CTQ_SENDING: begin
                    if (msgAborted) begin
                        sendReq_reg <= 1'b0;
                        state_reg <= CTQ_IDLE;
                    end else if (abortWr) begin
                        state_reg <= CTQ_ABORTING;
                    end else if (finish && (count_reg == 6'h01) && !advance) begin
                        sendReq_reg <= 1'b0;
                        state_reg <= CTQ_IDLE;
                    end
                end
                CTQ_ABORTING: begin
                    if (msgAborted || (finish && (count_reg == 6'h01) && !advance)) begin
                        sendReq_reg <= 1'b0;
                        state_reg <= CTQ_IDLE;
                    end
                end
                default: begin
                    state_reg <= CTQ_IDLE;
                    sendReq_reg <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // outcome of current message
    // ----------------------------------------
    // in-flight events held until the message ends
    always_ff @(posedge mclk) begin
        if (!rst_b || flushDone || msgSent || msgAborted) begin
            larbSeen_reg <= 1'b0;
            berrSeen_reg <= 1'b0;
        end else begin
            if (arbLost) begin
                larbSeen_reg <= 1'b1;
            end
            if (busError) begin
                berrSeen_reg <= 1'b1;
            end
        end
    end

    // completion status, set wins over host clear
    always_ff @(posedge mclk) begin
        if (!rst_b || flushDone) begin
            abt_reg <= 1'b0;
            larb_reg <= 1'b0;
            berr_reg <= 1'b0;
        end else if (msgSent || msgAborted) begin
            abt_reg <= msgAborted;
            larb_reg <= larbSeen_reg || arbLost;
            berr_reg <= berrSeen_reg || busError;
        end else if (setSend) begin
            abt_reg <= 1'b0;
            larb_reg <= 1'b0;
            berr_reg <= 1'b0;
        end else if (wrStat && regByteEn[`CTQ_LANE0]) begin
            abt_reg <= abt_reg && regWData[`CTQ_ABT_BIT];
            larb_reg <= larb_reg && regWData[`CTQ_LARB_BIT];
            berr_reg <= berr_reg && regWData[`CTQ_BERR_BIT];
        end
    end

    // attempts exhausted flag
    always_ff @(posedge mclk) begin
        if (!rst_b || flushDone) begin
            atIf_reg <= 1'b0;
        end else if (attemptsOut) begin
            atIf_reg <= 1'b1;
        end else if (wrStat && regByteEn[`CTQ_LANE0] && !regWData[`CTQ_ATIF_BIT]) begin
            atIf_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // engine-facing outputs
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sendPending <= 1'b0;
            abortRequest <= 1'b0;
            sendPriority <= 5'h00;
            retryMode <= `CTQ_RETRY_ENDLESS;
            queueIndex <= 5'h00;
            headAddress <= RAM_BASE;
            flushBusy <= 1'b1;
        end else begin
            sendPending <= sendReq_reg && (state_reg == CTQ_SENDING);
            abortRequest <= (state_reg == CTQ_ABORTING);
            sendPriority <= prio_reg;
            if (!retryLimitGlobal) begin
                retryMode <= `CTQ_RETRY_ENDLESS;
            end else if (retry_reg == 2'h0) begin
                retryMode <= `CTQ_RETRY_NONE;
            end else if (retry_reg == 2'h1) begin
                retryMode <= `CTQ_RETRY_THREE;
            end else begin
                retryMode <= `CTQ_RETRY_ENDLESS;
            end
            queueIndex <= tail_reg;
            headAddress <= RAM_BASE + 32'(head_reg) * 32'(payloadBytes(payload_size_reg) + `CTQ_HDR_BYTES);
            flushBusy <= flush_reg;
        end
    end

    // gated interrupt requests
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            emptyIrq <= 1'b0;
            notFullIrq <= 1'b0;
            attemptsIrq <= 1'b0;
        end else begin
            emptyIrq <= emIe_reg && queueEmpty;
            notFullIrq <= nfIe_reg && !queueFull;
            attemptsIrq <= atIe_reg && atIf_reg;
        end
    end

    // ----------------------------------------
    // register readback
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            regRData <= 32'h00000000;
            regRValid <= 1'b0;
        end else begin
            regRValid <= regRead;
            if (regRead) begin
                case (regAddr)
                    `CTQ_IDX_CTRL: begin
                        regRData <= {payload_size_reg, depth_reg, 1'b0, retry_reg, prio_reg, 5'h00, flush_reg,
                                     sendReq_reg, 1'b0, 1'b1, 2'b00, atIe_reg, 1'b0, emIe_reg, 1'b0,
                                     nfIe_reg};
                    end
                    `CTQ_IDX_STAT: begin
                        regRData <= {19'h00000, tail_reg, abt_reg, larb_reg, berr_reg, atIf_reg, 1'b0,
                                     queueEmpty, 1'b0, !queueFull};
                    end
                    `CTQ_IDX_UADDR: begin
                        regRData <= headAddress;
                    end
                    `CTQ_IDX_FIFO: begin
                        regRData <= fifoWord;
                    end
                    default: begin
                        regRData <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // general message fifo control
    // ----------------------------------------
    ctq_fifo_ctrl u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .configMode(configMode),
        .wrEn(wrFifo),
        .wrByteEn(regByteEn),
        .wrData(regWData),
        .ctrlWord(fifoWord),
        .fifoIsTransmit(fifoIsTransmit)
    );

endmodule : ctq_tx_queue
`default_nettype wire

//--- tb/ctq_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctq_engine_model (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // from the queue
    input wire logic sendPending,
    input wire logic abortRequest,
    // scenario knobs
    input wire logic [1:0] faultKind,
    input wire logic [3:0] gap,
    // outcome pulses
    output logic msgSent,
    output logic msgAborted,
    output logic arbLost,
    output logic busError,
    output logic attemptsOut
);
    logic [3:0] waitCnt;
    // one outcome every gap+1 cycles while sending, faults early in each message
    always_ff @(posedge mclk) begin
        {msgSent, msgAborted, arbLost, busError, attemptsOut} <= 5'h00;
        if (!rst_b || !(sendPending || abortRequest)) begin
            waitCnt <= 4'h0;
        end else if (waitCnt == gap) begin
            waitCnt <= 4'h0;
            msgSent <= !abortRequest;
            msgAborted <= abortRequest;
        end else begin
            waitCnt <= waitCnt + 4'h1;
            if (waitCnt == 4'h2) begin
                {arbLost, busError} <= {2{faultKind[1]}};
                attemptsOut <= faultKind[0];
            end
        end
    end
endmodule : ctq_engine_model
`default_nettype wire

//--- tb/ctq_tx_queue_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ctq_tx_queue_asserts (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // inputs
    input wire logic configMode,
    input wire logic retryLimitGlobal,
    input wire logic regWrite,
    input wire logic [3:0] regAddr,
    input wire logic [3:0] regByteEn,
    input wire logic [31:0] regWData,
    input wire logic msgSent,
    input wire logic msgAborted,
    // outputs
    input wire logic sendPending,
    input wire logic abortRequest,
    input wire logic [1:0] retryMode,
    input wire logic flushBusy,
    input wire logic fifoIsTransmit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [3:0] doneHist;
    // recent engine outcomes
    always_ff @(posedge mclk) begin
        doneHist <= {doneHist[2:0], msgSent || msgAborted};
    end
    // host writes to the send bit
    sequence sendWr(bit v);
        regWrite && regAddr == 4'h0 && regByteEn[1] && regWData[9] == v;
    endsequence
    reset_flush_a: assert property ($rose(rst_b) |-> flushBusy)
        else $error("flush bit low after reset");
    flush_hold_a: assert property (configMode [*3] |-> flushBusy)
        else $error("flush bit dropped in configuration");
    flush_clear_a: assert property (flushBusy && !configMode |-> ##[1:2] (!flushBusy || configMode))
        else $error("flush bit did not self clear");
    send_start_a: assert property (sendWr(1'b1) ##0 (!flushBusy && !sendPending) |-> ##[1:3] sendPending)
        else $error("send request not raised");
    send_drop_a: assert property ($fell(sendPending) |-> (doneHist != 4'h0 || abortRequest))
        else $error("send request dropped without outcome");
    abort_req_a: assert property (sendWr(1'b0) ##0 (sendPending && !abortRequest) |-> ##[1:3] abortRequest)
        else $error("abort not requested");
    abort_end_a: assert property (msgAborted |-> ##[1:3] (!sendPending && !abortRequest))
        else $error("send request kept after abort");
    retry_free_a: assert property (!retryLimitGlobal [*2] |-> retryMode == 2'h2)
        else $error("retry limited without global option");
    dir_frozen_a: assert property (!configMode [*3] |-> $stable(fifoIsTransmit))
        else $error("direction changed outside configuration");
endmodule : ctq_tx_queue_asserts
bind ctq_tx_queue ctq_tx_queue_asserts ctq_tx_queue_asserts_i (.*);
`default_nettype wire

//--- tb/ctq_tx_queue_test.sv
`timescale 1ns/1ps
`default_nettype none
module ctq_tx_queue_test;
    localparam logic [31:0] BASE = 32'h0000_1000;
    logic mclk = 1'b0, rst_b = 1'b0, configMode = 1'b1, retryLimitGlobal = 1'b0;
    logic regWrite = 1'b0, regRead = 1'b0, regRValid, msgSent, msgAborted, arbLost, busError;
    logic attemptsOut, sendPending, abortRequest, flushBusy, emptyIrq, notFullIrq, attemptsIrq, fifoIsTransmit;
    logic [3:0] regAddr = 4'h0, regByteEn = 4'h0, gap = 4'h5;
    logic [31:0] regWData = 32'h0, regRData, headAddress, rdv;
    logic [4:0] sendPriority, queueIndex;
    logic [1:0] retryMode, faultKind = 2'h0;
    logic [6:0] sz [8] = '{7'h08, 7'h0C, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
    int error_cnt = 0, n_checks = 0, cycles = 0;
    ctq_tx_queue #(.RAM_BASE(BASE)) ctq_tx_queue_i (.*);
    ctq_engine_model ctq_engine_model_i (.*);
    // clock and hang guard
    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, be, input logic [31:0] d);
        @(posedge mclk) #1;
        {regWrite, regAddr, regByteEn, regWData} = {1'b1, a, be, d};
        @(posedge mclk) #1;
        regWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge mclk) #1;
        {regRead, regAddr} = {1'b1, a};
        @(posedge mclk) #1;
        regRead = 1'b0;
        chk("read valid", {31'h0, regRValid}, 32'h1);
        rdv = regRData;
    endtask : rd
    task automatic settle();
        repeat (3) @(posedge mclk) #1;
        for (int k = 0; k < 60 && {flushBusy, sendPending, abortRequest} !== 3'h0; k++) @(posedge mclk) #1;
        chk("idle", {29'h0, flushBusy, sendPending, abortRequest}, 32'h0);
    endtask : settle
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        #1 rst_b = 1'b1;
        rd(4'h0);
        chk("ctrl reset", rdv, 32'h0060_0480);
        rd(4'h1);
        chk("status reset", rdv, 32'h0000_0005);
        rd(4'h9);
        chk("unmapped", rdv, 32'h0);
        wr(4'h3, 4'h1, 32'h0000_0080);
        @(posedge mclk) #1;
        chk("fifo dir", {31'h0, fifoIsTransmit}, 32'h1);
        $display("reset test done");
        for (int c = 0; c < 8; c++) begin
            configMode = 1'b1;
            wr(4'h0, 4'h8, {c[2:0], 5'h01, 24'h0});
            configMode = 1'b0;
            settle();
            wr(4'h0, 4'h2, 32'h0000_0100);
            rd(4'h2);
            chk("head", rdv, BASE + 32'h8 + sz[c]);
            wr(4'h0, 4'h2, 32'h0000_0100);
            rd(4'h1);
            chk("full", rdv, 32'h0);
            wr(4'h0, 4'h2, 32'h0000_0100);
            rd(4'h2);
            chk("wrap", rdv, BASE);
        end
        wr(4'h0, 4'h8, 32'h0);
        wr(4'h3, 4'h1, 32'h0);
        rd(4'h0);
        chk("locked", {23'h0, rdv[31:24], fifoIsTransmit}, 32'h1C3);
        retryLimitGlobal = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(4'h0, 4'h4, {9'h0, c[1:0], c[0] ? 5'h1F : 5'h00, 16'h0});
            @(posedge mclk) #1;
            chk("retry prio", {25'h0, sendPriority, retryMode}, {25'h0, c[0] ? 5'h1F : 5'h00, c[1] ? 2'h2 : c[1:0]});
        end
        $display("config test done");
        wr(4'h0, 4'h1, 32'h0000_0015);
        chk("irq full", {29'h0, attemptsIrq, emptyIrq, notFullIrq}, 32'h0);
        faultKind = 2'h3;
        wr(4'h0, 4'h2, 32'h0000_0200);
        settle();
        rd(4'h1);
        chk("outcome", rdv, 32'h0000_0075);
        chk("irqs", {29'h0, attemptsIrq, emptyIrq, notFullIrq}, 32'h7);
        wr(4'h1, 4'h1, 32'h0);
        rd(4'h1);
        chk("status clear", rdv, 32'h0000_0005);
        wr(4'h0, 4'h1, 32'h0);
        @(posedge mclk) #1;
        chk("irq masked", {29'h0, attemptsIrq, emptyIrq, notFullIrq}, 32'h0);
        $display("send test done");
        {faultKind, gap} = {2'h0, 4'hF};
        wr(4'h0, 4'h2, 32'h0000_0100);
        wr(4'h0, 4'h2, 32'h0000_0200);
        wr(4'h0, 4'h2, 32'h0);
        settle();
        rd(4'h1);
        chk("aborted", rdv & 32'hE0, 32'h80);
        wr(4'h0, 4'h2, 32'h0000_0200);
        rd(4'h1);
        chk("resend clear", rdv & 32'hE0, 32'h0);
        settle();
        rd(4'h1);
        chk("drained", rdv, 32'h0000_0105);
        chk("index", {27'h0, queueIndex}, 32'h1);
        $display("abort test done");
        wr(4'h0, 4'h2, 32'h0000_0100);
        wr(4'h0, 4'h2, 32'h0000_0400);
        settle();
        rd(4'h1);
        chk("flush status", rdv, 32'h0000_0005);
        rd(4'h2);
        chk("flush head", rdv, BASE);
        chk("head out", headAddress, BASE);
        $display("flush test done");
        complete_run();
    end
endmodule : ctq_tx_queue_test
`default_nettype wire
